//--- core/pdts_defs.svh
// Constants for the preamble detection and timing synchronisation block.
// Function
// - Matched filter every received I/Q sample.
// - Filtered samples go to buffer and detector.
// - Correlate with timing preamble taps, then magnitude/phase.
// - Correlator magnitude is the detection metric.
// - Correlator phase gives the coarse phase estimate.
// - Track buffer address of the metric maximum.
// - Accept peak only above detection threshold.
// - After peak, read buffer from synchronised position.
// - Buffer output feeds several estimators at once.
// - Frame sync high exactly during frequency preamble.
// - Sample valid marks meaningful buffer output.
// - Enable input gates detection and synchronisation.
// - Read configured sample count before next search.
// - Configuration input selects continuous preamble mode.
// - Machine records peaks as write pointer addresses.
// - Machine drives and exposes buffer read pointer.
// - Frequency preamble length bounds frame sync interval.
// - Wait for coding rate ready before continuing.
// - Output coarse phase taken at detected peak.
// - Only leading frequency preamble samples feed estimator.
// - Transform frequency preamble, find strongest bin.
// - Frequency metric uses peak bin and samples.
// - Receiver disabled means no samples are accepted.
`ifndef PDTS_DEFS_SVH
`define PDTS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------
`define PDTS_CTRL_OFS 8'h00
`define PDTS_THRESH_OFS 8'h04
`define PDTS_FLEN_OFS 8'h08
`define PDTS_RNUM_OFS 8'h0c
`define PDTS_STATUS_OFS 8'h10
`define PDTS_RESULT_OFS 8'h14
`define PDTS_METRIC_I_OFS 8'h18
`define PDTS_METRIC_Q_OFS 8'h1c
`define PDTS_CTRL_EN_BIT 0
`define PDTS_CTRL_CONT_BIT 1
`define PDTS_STATUS_DONE_BIT 3
`define PDTS_STATUS_PEAK_LSB 16
`define PDTS_RESULT_BIN_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PDTS_CTRL_RST 2'h0
`define PDTS_THRESH_RST 32'h00001000
`define PDTS_FLEN_RST 16'h0040
`define PDTS_RNUM_RST 16'h0400

// ----------------------------------------------------------------------
// Structure and timing counts
// ----------------------------------------------------------------------
`define PDTS_BUF_AW 10
`define PDTS_WIN_LEN 16
`define PDTS_RRC_TAPS 5
`define PDTS_ZC_LEN 8
`define PDTS_DFT_N 8
`define PDTS_COEF_SHIFT 7

`endif

//--- core/pdts_pkg.sv
// Types shared by the preamble detection and timing synchronisation block.
package pdts_pkg;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } pdts_iq_type;

  typedef enum logic [2:0] {
    PDTS_IDLE = 3'h0,
    PDTS_SEARCH = 3'h1,
    PDTS_FREQ = 3'h3,
    PDTS_WAIT = 3'h2,
    PDTS_REST = 3'h6
  } pdts_state_type;

endpackage : pdts_pkg

//--- core/pdts_top.sv
// Matched filter, preamble correlator, sync machine, input buffer and coarse frequency estimator.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "pdts_defs.svh"
module pdts_top
  import pdts_pkg::*;
#(
  parameter int AW = `PDTS_BUF_AW,
  parameter int WIN_LEN = `PDTS_WIN_LEN
)
(
  // Clock and reset.
  input logic clk,
  input logic rstn,
  // Sample stream from the upstream source.
  input pdts_iq_type in_sample,
  input logic in_valid,
  // Coding rate evaluation handshake.
  input logic cri_ready,
  // Register port.
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  // Buffer read stream to downstream estimators.
  output pdts_iq_type buf_sample,
  output logic buf_valid,
  output logic frame_sync,
  output logic [AW-1:0] read_addr,
  output logic [AW-1:0] write_addr,
  // Estimator results.
  output logic [2:0] coarse_phase,
  output logic [2:0] freq_bin,
  output logic freq_done
);

  // ----------------------------------------------------------------------
  // Coefficient tables
  // ----------------------------------------------------------------------
  localparam int RT = `PDTS_RRC_TAPS;
  localparam int ZL = `PDTS_ZC_LEN;
  localparam int DN = `PDTS_DFT_N;
  localparam int SH = `PDTS_COEF_SHIFT;
  // Default Q7 tables; a different pulse shape or sequence only changes these values.
  localparam logic signed [7:0] RRC_COEF [RT] = '{8'shf6, 8'sh1e, 8'sh50, 8'sh1e, 8'shf6};
  localparam logic signed [7:0] ZC_RE [ZL] =
    '{8'sh7f, 8'sh76, 8'sh00, 8'sh8a, 8'sh7f, 8'sh8a, 8'sh00, 8'sh76};
  localparam logic signed [7:0] ZC_IM [ZL] =
    '{8'sh00, 8'shcf, 8'sh81, 8'sh31, 8'sh00, 8'sh31, 8'sh81, 8'shcf};
  localparam logic signed [7:0] TW_COS [DN] =
    '{8'sh7f, 8'sh5a, 8'sh00, 8'sha6, 8'sh81, 8'sha6, 8'sh00, 8'sh5a};
  localparam logic signed [7:0] TW_SIN [DN] =
    '{8'sh00, 8'sh5a, 8'sh7f, 8'sh5a, 8'sh00, 8'sha6, 8'sh81, 8'sha6};

  function automatic logic [31:0] mag_abs(input logic signed [31:0] v);
    mag_abs = v[31] ? (~v + 32'h1) : v;
  endfunction : mag_abs

  // Octant of the vector in units of 45 degrees, counted from the positive I axis.
  function automatic logic [2:0] octant(input logic signed [31:0] vi, input logic signed [31:0] vq);
    logic [31:0] ai;
    logic [31:0] aq;
    ai = mag_abs(vi);
    aq = mag_abs(vq);
    if (!vq[31])
      octant = !vi[31] ? ((ai >= aq) ? 3'h0 : 3'h1) : ((aq > ai) ? 3'h2 : 3'h3);
    else
      octant = vi[31] ? ((ai >= aq) ? 3'h4 : 3'h5) : ((aq > ai) ? 3'h6 : 3'h7);
  endfunction : octant

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [31:0] thresh_reg;
  logic [15:0] flen_reg;
  logic [15:0] rnum_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  pdts_state_type state_reg;
  pdts_state_type state_next;
  logic [AW-1:0] peak_addr_reg;
  logic [2:0] peak_phase_reg;
  logic [2:0] best_bin_reg;
  logic fe_done_reg;
  logic signed [31:0] met_i_reg;
  logic signed [31:0] met_q_reg;

  wire rx_en = ctrl_reg[`PDTS_CTRL_EN_BIT];
  wire cont_mode = ctrl_reg[`PDTS_CTRL_CONT_BIT];
  wire sync_en = rx_en;

  always_comb
  begin
    rdata_next = 32'h0;
    if (reg_addr == `PDTS_CTRL_OFS)
      rdata_next = {30'h0, ctrl_reg};
    else if (reg_addr == `PDTS_THRESH_OFS)
      rdata_next = thresh_reg;
    else if (reg_addr == `PDTS_FLEN_OFS)
      rdata_next = {16'h0, flen_reg};
    else if (reg_addr == `PDTS_RNUM_OFS)
      rdata_next = {16'h0, rnum_reg};
    else if (reg_addr == `PDTS_STATUS_OFS)
      rdata_next = {16'(peak_addr_reg), 12'h0, fe_done_reg, state_reg};
    else if (reg_addr == `PDTS_RESULT_OFS)
      rdata_next = {21'h0, best_bin_reg, 5'h0, peak_phase_reg};
    else if (reg_addr == `PDTS_METRIC_I_OFS)
      rdata_next = met_i_reg;
    else if (reg_addr == `PDTS_METRIC_Q_OFS)
      rdata_next = met_q_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `PDTS_CTRL_RST;
      thresh_reg <= `PDTS_THRESH_RST;
      flen_reg <= `PDTS_FLEN_RST;
      rnum_reg <= `PDTS_RNUM_RST;
      rdata_reg <= 32'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == `PDTS_CTRL_OFS) ctrl_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `PDTS_THRESH_OFS) thresh_reg <= reg_wdata;
      if (reg_wr && reg_addr == `PDTS_FLEN_OFS) flen_reg <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `PDTS_RNUM_OFS) rnum_reg <= reg_wdata[15:0];
      rdata_reg <= reg_rd ? rdata_next : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Matched filter and input buffer write side
  // ----------------------------------------------------------------------
  pdts_iq_type in_hist [RT];
  pdts_iq_type cor_hist [ZL];
  pdts_iq_type buf_mem [2**AW];
  logic signed [26:0] rrc_i;
  logic signed [26:0] rrc_q;
  logic mf_valid_reg;
  pdts_iq_type mf_reg;
  logic [AW-1:0] wr_ptr_reg;
  logic cor_step_reg;
  logic [AW-1:0] cor_addr_reg;

  wire accept = in_valid && rx_en;

  always_comb
  begin
    rrc_i = 27'sh0;
    rrc_q = 27'sh0;
    for (int k = 0; k < RT; k++)
    begin
      rrc_i = rrc_i + 27'(in_hist[k].i * RRC_COEF[k]);
      rrc_q = rrc_q + 27'(in_hist[k].q * RRC_COEF[k]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int k = 0; k < RT; k++) in_hist[k] <= '0;
      for (int k = 0; k < ZL; k++) cor_hist[k] <= '0;
      mf_valid_reg <= 1'b0;
      mf_reg <= '0;
      wr_ptr_reg <= '0;
      cor_step_reg <= 1'b0;
      cor_addr_reg <= '0;
    end
    else
    begin
      if (accept)
      begin
        in_hist[0] <= in_sample;
        for (int k = 1; k < RT; k++) in_hist[k] <= in_hist[k-1];
      end
      // The filter output is taken on the same edge the sample enters the taps, so it leaves that sample out.
      mf_valid_reg <= accept;
      mf_reg.i <= rrc_i[SH+15:SH];
      mf_reg.q <= rrc_q[SH+15:SH];
      cor_step_reg <= mf_valid_reg;
      if (mf_valid_reg)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
        cor_addr_reg <= wr_ptr_reg;
        cor_hist[0] <= mf_reg;
        for (int k = 1; k < ZL; k++) cor_hist[k] <= cor_hist[k-1];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (mf_valid_reg) buf_mem[wr_ptr_reg] <= mf_reg;
  end

  // ----------------------------------------------------------------------
  // Preamble correlator
  // ----------------------------------------------------------------------
  logic signed [27:0] cor_i;
  logic signed [27:0] cor_q;
  logic [31:0] cmag_reg;
  logic [2:0] cphase_reg;
  logic [AW-1:0] caddr_reg;
  logic cvalid_reg;

  always_comb
  begin
    cor_i = 28'sh0;
    cor_q = 28'sh0;
    for (int n = 0; n < ZL; n++)
    begin
      cor_i = cor_i + 28'(cor_hist[ZL-1-n].i * ZC_RE[n]) + 28'(cor_hist[ZL-1-n].q * ZC_IM[n]);
      cor_q = cor_q + 28'(cor_hist[ZL-1-n].q * ZC_RE[n]) - 28'(cor_hist[ZL-1-n].i * ZC_IM[n]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cmag_reg <= 32'h0;
      cphase_reg <= 3'h0;
      caddr_reg <= '0;
      cvalid_reg <= 1'b0;
    end
    else
    begin
      cvalid_reg <= cor_step_reg;
      cmag_reg <= mag_abs(32'(cor_i >>> SH)) + mag_abs(32'(cor_q >>> SH));
      cphase_reg <= octant(32'(cor_i), 32'(cor_q));
      caddr_reg <= cor_addr_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Sync machine and buffer read side
  // ----------------------------------------------------------------------
  logic [31:0] peak_mag_reg;
  logic armed_reg;
  logic [15:0] win_cnt_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [15:0] rd_cnt_reg;
  pdts_iq_type buf_sample_reg;
  logic buf_valid_reg;
  logic frame_sync_reg;

  wire above = cmag_reg > thresh_reg;
  wire take_peak = (state_reg == PDTS_SEARCH) && cvalid_reg && above &&
    (!armed_reg || cmag_reg > peak_mag_reg);
  wire win_done = (state_reg == PDTS_SEARCH) && cvalid_reg && armed_reg &&
    (win_cnt_reg == 16'(WIN_LEN - 1));
  // A larger metric in the last window slot must move the read start as well.
  wire [AW-1:0] start_addr = take_peak ? caddr_reg : peak_addr_reg;
  wire reading = (state_reg == PDTS_FREQ) || (state_reg == PDTS_REST);
  wire rd_go = reading && (rd_ptr_reg != wr_ptr_reg);
  wire [16:0] rd_cnt_inc = {1'b0, rd_cnt_reg} + 17'h1;
  wire freq_last = rd_go && (state_reg == PDTS_FREQ) && (rd_cnt_inc >= {1'b0, flen_reg});
  wire rest_last = rd_go && (state_reg == PDTS_REST) && (rd_cnt_inc >= {1'b0, rnum_reg});

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PDTS_IDLE: state_next = PDTS_SEARCH;
      PDTS_SEARCH: if (win_done) state_next = PDTS_FREQ;
      PDTS_FREQ: if (freq_last) state_next = cont_mode ? PDTS_SEARCH : PDTS_WAIT;
      PDTS_WAIT: if (cri_ready) state_next = PDTS_REST;
      PDTS_REST: if (rest_last) state_next = PDTS_SEARCH;
      default: state_next = PDTS_IDLE;
    endcase
    if (!sync_en) state_next = PDTS_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= PDTS_IDLE;
      peak_mag_reg <= 32'h0;
      armed_reg <= 1'b0;
      win_cnt_reg <= 16'h0;
      peak_addr_reg <= '0;
      peak_phase_reg <= 3'h0;
      rd_ptr_reg <= '0;
      rd_cnt_reg <= 16'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != PDTS_SEARCH)
      begin
        armed_reg <= 1'b0;
        win_cnt_reg <= 16'h0;
      end
      else if (cvalid_reg && armed_reg)
        win_cnt_reg <= win_cnt_reg + 16'h1;
      if (take_peak)
      begin
        armed_reg <= 1'b1;
        peak_mag_reg <= cmag_reg;
        peak_addr_reg <= caddr_reg;
        peak_phase_reg <= cphase_reg;
      end
      if (win_done)
      begin
        rd_ptr_reg <= start_addr + 1'b1;
        rd_cnt_reg <= 16'h0;
      end
      else if (rd_go)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        rd_cnt_reg <= rd_cnt_inc[15:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      buf_sample_reg <= '0;
      buf_valid_reg <= 1'b0;
      frame_sync_reg <= 1'b0;
    end
    else
    begin
      if (rd_go) buf_sample_reg <= buf_mem[rd_ptr_reg];
      buf_valid_reg <= rd_go && sync_en;
      frame_sync_reg <= rd_go && sync_en && (state_reg == PDTS_FREQ);
    end
  end

  // ----------------------------------------------------------------------
  // Coarse frequency estimator
  // ----------------------------------------------------------------------
  pdts_iq_type fe_mem [DN];
  pdts_iq_type fe_prev_reg;
  logic [15:0] fe_cnt_reg;
  logic signed [39:0] lag_i_reg;
  logic signed [39:0] lag_q_reg;
  logic fe_run_reg;
  logic fe_fin_reg;
  logic [2:0] fe_k_reg;
  logic [2:0] fe_n_reg;
  logic signed [31:0] acc_i_reg;
  logic signed [31:0] acc_q_reg;
  logic [31:0] best_mag_reg;

  wire [2:0] tw_idx = 3'(fe_k_reg * fe_n_reg);
  wire signed [31:0] term_i = 32'(fe_mem[fe_n_reg].i * TW_COS[tw_idx]) +
    32'(fe_mem[fe_n_reg].q * TW_SIN[tw_idx]);
  wire signed [31:0] term_q = 32'(fe_mem[fe_n_reg].q * TW_COS[tw_idx]) -
    32'(fe_mem[fe_n_reg].i * TW_SIN[tw_idx]);
  wire signed [31:0] sum_i = acc_i_reg + term_i;
  wire signed [31:0] sum_q = acc_q_reg + term_q;
  wire [31:0] bin_mag = mag_abs(sum_i) + mag_abs(sum_q);
  wire fe_take = frame_sync_reg && buf_valid_reg && (fe_cnt_reg < 16'(DN));
  // Lag product rotated back by the peak bin leaves only the residual offset.
  wire signed [47:0] rot_i = 48'(lag_i_reg * TW_COS[best_bin_reg]) +
    48'(lag_q_reg * TW_SIN[best_bin_reg]);
  wire signed [47:0] rot_q = 48'(lag_q_reg * TW_COS[best_bin_reg]) -
    48'(lag_i_reg * TW_SIN[best_bin_reg]);

  always_ff @(posedge clk)
  begin
    if (!rstn || win_done)
    begin
      for (int k = 0; k < DN; k++) fe_mem[k] <= '0;
      fe_prev_reg <= '0;
      fe_cnt_reg <= 16'h0;
      lag_i_reg <= 40'sh0;
      lag_q_reg <= 40'sh0;
      fe_run_reg <= 1'b0;
      fe_fin_reg <= 1'b0;
      fe_k_reg <= 3'h0;
      fe_n_reg <= 3'h0;
      acc_i_reg <= 32'sh0;
      acc_q_reg <= 32'sh0;
      best_mag_reg <= 32'h0;
      best_bin_reg <= 3'h0;
      fe_done_reg <= 1'b0;
      met_i_reg <= 32'sh0;
      met_q_reg <= 32'sh0;
    end
    else
    begin
      if (fe_take)
      begin
        fe_mem[fe_cnt_reg[2:0]] <= buf_sample_reg;
        fe_prev_reg <= buf_sample_reg;
        fe_cnt_reg <= fe_cnt_reg + 16'h1;
        if (fe_cnt_reg != 16'h0)
        begin
          lag_i_reg <= lag_i_reg + 40'(buf_sample_reg.i * fe_prev_reg.i) +
            40'(buf_sample_reg.q * fe_prev_reg.q);
          lag_q_reg <= lag_q_reg + 40'(buf_sample_reg.q * fe_prev_reg.i) -
            40'(buf_sample_reg.i * fe_prev_reg.q);
        end
      end
      // The transform starts once the frequency preamble has been fully emitted.
      if (state_reg != PDTS_FREQ && !frame_sync_reg && fe_cnt_reg != 16'h0 &&
          !fe_run_reg && !fe_fin_reg && !fe_done_reg)
        fe_run_reg <= 1'b1;
      fe_fin_reg <= 1'b0;
      if (fe_run_reg)
      begin
        fe_n_reg <= fe_n_reg + 3'h1;
        acc_i_reg <= (fe_n_reg == 3'h7) ? 32'sh0 : sum_i;
        acc_q_reg <= (fe_n_reg == 3'h7) ? 32'sh0 : sum_q;
        if (fe_n_reg == 3'h7)
        begin
          fe_k_reg <= fe_k_reg + 3'h1;
          if (fe_k_reg == 3'h0 || bin_mag > best_mag_reg)
          begin
            best_mag_reg <= bin_mag;
            best_bin_reg <= fe_k_reg;
          end
          if (fe_k_reg == 3'h7)
          begin
            fe_run_reg <= 1'b0;
            fe_fin_reg <= 1'b1;
          end
        end
      end
      if (fe_fin_reg)
      begin
        met_i_reg <= rot_i[SH+31:SH];
        met_q_reg <= rot_q[SH+31:SH];
        fe_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign buf_sample = buf_sample_reg;
  assign buf_valid = buf_valid_reg;
  assign frame_sync = frame_sync_reg;
  assign read_addr = rd_ptr_reg;
  assign write_addr = wr_ptr_reg;
  assign coarse_phase = peak_phase_reg;
  assign freq_bin = best_bin_reg;
  assign freq_done = fe_done_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_no_accept_when_off;
    !rx_en |=> !mf_valid_reg;
  endproperty
  a_no_accept_when_off: assert property (p_no_accept_when_off)
    else $error("sample accepted while receiver disabled");

  property p_write_advance;
    mf_valid_reg |=> wr_ptr_reg == $past(wr_ptr_reg) + 1'b1;
  endproperty
  a_write_advance: assert property (p_write_advance)
    else $error("write pointer did not advance on filtered sample");

  property p_strict_threshold;
    state_reg == PDTS_SEARCH && !armed_reg && cvalid_reg && cmag_reg <= thresh_reg |=> !armed_reg;
  endproperty
  a_strict_threshold: assert property (p_strict_threshold)
    else $error("peak taken at or below threshold");

  property p_peak_addr;
    take_peak |=> peak_addr_reg == $past(caddr_reg) && peak_phase_reg == $past(cphase_reg);
  endproperty
  a_peak_addr: assert property (p_peak_addr)
    else $error("peak address or phase not recorded");

  property p_read_start;
    win_done && sync_en |=> state_reg == PDTS_FREQ && rd_ptr_reg == peak_addr_reg + 1'b1;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read did not start after peak");

  property p_sync_with_valid;
    frame_sync_reg |-> buf_valid_reg && $past(state_reg) == PDTS_FREQ;
  endproperty
  a_sync_with_valid: assert property (p_sync_with_valid)
    else $error("frame sync outside frequency preamble read");

  property p_sync_bound;
    frame_sync_reg && $past(flen_reg) != 16'h0 |-> $past(rd_cnt_reg) < $past(flen_reg);
  endproperty
  a_sync_bound: assert property (p_sync_bound)
    else $error("frame sync longer than preamble length");

  property p_valid_read;
    buf_valid_reg |-> $past(rd_ptr_reg) != $past(wr_ptr_reg) && rd_ptr_reg != $past(rd_ptr_reg);
  endproperty
  a_valid_read: assert property (p_valid_read)
    else $error("sample valid without buffer read");

  property p_disable_idle;
    !sync_en |=> state_reg == PDTS_IDLE ##1 !buf_valid_reg;
  endproperty
  a_disable_idle: assert property (p_disable_idle)
    else $error("machine not idle after disable");

  property p_wait_cri;
    state_reg == PDTS_WAIT && !cri_ready && sync_en |=> state_reg == PDTS_WAIT;
  endproperty
  a_wait_cri: assert property (p_wait_cri)
    else $error("left wait state without coding rate ready");

endmodule : pdts_top

//--- tb/pdts_src_model.sv
// Upstream sample source model that feeds the detection block.
`timescale 1ns/10ps
module pdts_src_model
  import pdts_pkg::*;
(
  // Clock and control.
  input wire logic clk,
  input wire logic run,
  // Sample stream.
  output pdts_iq_type in_sample,
  output logic in_valid
);
  logic v;
  initial
  begin
    in_sample = '0;
    in_valid = 1'b0;
  end
  // Gaps make the source slow at times; idle data is inverted so it never looks fresh.
  always @(posedge clk)
  begin
    v = run && ($urandom_range(3) != 0);
    in_valid <= v;
    in_sample <= v ? pdts_iq_type'({16'($urandom), 16'($urandom)}) : ~in_sample;
  end
endmodule : pdts_src_model

//--- tb/testbench.sv
// Self-checking bench for the detection and timing synchronisation block.
`timescale 1ns/10ps
`include "pdts_defs.svh"
module testbench
  import pdts_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, run = 1'b0, cri_ready = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, flen, rnum, emi, emq;
  pdts_iq_type in_sample, buf_sample;
  pdts_iq_type cap[8] = '{default: '0};
  logic in_valid, buf_valid, frame_sync, freq_done;
  logic [5:0] read_addr, write_addr, wa0;
  logic [2:0] coarse_phase, freq_bin;
  int n_errors = 0, total_checks = 0, n_bv = 0, n_sync = 0, b0, s0, k, eb;
  logic [7:0] ra[7] = '{`PDTS_CTRL_OFS, `PDTS_THRESH_OFS, `PDTS_FLEN_OFS, `PDTS_RNUM_OFS,
    `PDTS_STATUS_OFS, `PDTS_RESULT_OFS, 8'h40};
  logic [31:0] rv[7] = '{32'h0, `PDTS_THRESH_RST, 32'(`PDTS_FLEN_RST), 32'(`PDTS_RNUM_RST),
    32'h0, 32'h0, 32'h0};

  pdts_src_model src (.clk(clk), .run(run), .in_sample(in_sample), .in_valid(in_valid));
  pdts_top #(.AW(6), .WIN_LEN(4)) dut (.clk(clk), .rstn(rstn), .in_sample(in_sample),
    .in_valid(in_valid), .cri_ready(cri_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_sample(buf_sample),
    .buf_valid(buf_valid), .frame_sync(frame_sync), .read_addr(read_addr),
    .write_addr(write_addr), .coarse_phase(coarse_phase), .freq_bin(freq_bin),
    .freq_done(freq_done));

  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (buf_valid === 1'b1) n_bv++;
    if (frame_sync === 1'b1)
    begin
      if (n_sync < 8) cap[n_sync] = buf_sample;
      n_sync++;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so it is sampled just after that edge.
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task wait_st(input logic [2:0] st);
    for (k = 0; k < 300; k++)
    begin
      rd(`PDTS_STATUS_OFS);
      if (d[2:0] === st) break;
    end
  endtask : wait_st
  // The frequency part always reads at least one sample and the total never falls below it.
  function int exp_reads(input int fl, input int rn);
    int f1;
    f1 = (fl == 0) ? 1 : fl;
    return (rn > f1) ? rn : f1 + 1;
  endfunction : exp_reads
  // Eight-point transform of the first captured preamble, then the lag sum turned back by its bin.
  function automatic void exp_freq(output int b, output logic [31:0] mi, output logic [31:0] mq);
    int c[8] = '{127, 90, 0, -90, -127, -90, 0, 90};
    int s[8] = '{0, 90, 127, 90, 0, -90, -127, -90};
    longint re, im, m, best, li, lq;
    int x;
    best = -1;
    b = 0;
    li = 0;
    lq = 0;
    for (int kk = 0; kk < 8; kk++)
    begin
      re = 0;
      im = 0;
      for (int nn = 0; nn < 8; nn++)
      begin
        x = (kk * nn) % 8;
        re += cap[nn].i * c[x] + cap[nn].q * s[x];
        im += cap[nn].q * c[x] - cap[nn].i * s[x];
      end
      m = (re < 0 ? -re : re) + (im < 0 ? -im : im);
      if (m > best)
      begin
        best = m;
        b = kk;
      end
    end
    for (int nn = 1; nn < 8; nn++)
    begin
      li += cap[nn].i * cap[nn-1].i + cap[nn].q * cap[nn-1].q;
      lq += cap[nn].q * cap[nn-1].i - cap[nn].i * cap[nn-1].q;
    end
    mi = 32'((li * c[b] + lq * s[b]) >>> 7);
    mq = 32'((lq * c[b] - li * s[b]) >>> 7);
  endfunction : exp_freq
  task report_and_stop;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #80000;
    n_errors++;
    report_and_stop;
  end

  initial
  begin
    void'($urandom(8));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    wr(`PDTS_RESULT_OFS, 32'hffffffff);
    rd(`PDTS_RESULT_OFS);
    chk(d, 32'h0);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(write_addr), 32'h0);
    wr(`PDTS_THRESH_OFS, 32'hffffffff);
    wr(`PDTS_CTRL_OFS, 32'h1);
    repeat (200) @(posedge clk);
    rd(`PDTS_STATUS_OFS);
    chk(32'(d[2:0]), 32'(PDTS_SEARCH));
    chk(n_bv, 0);
    wa0 = write_addr;
    repeat (8) @(posedge clk);
    chk(32'(write_addr != wa0), 32'h1);
    flen = 3 + $urandom_range(3);
    rnum = flen + 2 + $urandom_range(9);
    wr(`PDTS_FLEN_OFS, flen);
    wr(`PDTS_RNUM_OFS, rnum);
    wr(`PDTS_THRESH_OFS, 32'h1);
    wait_st(PDTS_WAIT);
    chk(32'(d[2:0]), 32'(PDTS_WAIT));
    chk(32'(read_addr), 32'(6'(d[21:16] + 6'h1 + 6'(flen))));
    wr(`PDTS_THRESH_OFS, 32'hffffffff);
    chk(n_sync, flen);
    chk(n_bv, flen);
    repeat (30) @(posedge clk);
    chk(n_bv, flen);
    for (k = 0; k < 300 && freq_done !== 1'b1; k++) @(posedge clk);
    chk(32'(freq_done), 32'h1);
    exp_freq(eb, emi, emq);
    rd(`PDTS_RESULT_OFS);
    chk(32'(d[10:8]), 32'(eb));
    chk(32'(freq_bin), 32'(eb));
    chk(32'(coarse_phase), 32'(d[2:0]));
    rd(`PDTS_METRIC_I_OFS);
    chk(d, emi);
    rd(`PDTS_METRIC_Q_OFS);
    chk(d, emq);
    cri_ready <= 1'b1;
    wait_st(PDTS_SEARCH);
    chk(32'(d[2:0]), 32'(PDTS_SEARCH));
    repeat (4) @(posedge clk);
    chk(n_bv, exp_reads(flen, rnum));
    cri_ready <= 1'b0;
    s0 = n_sync;
    wr(`PDTS_CTRL_OFS, 32'h3);
    wr(`PDTS_THRESH_OFS, 32'h1);
    for (k = 0; k < 3000 && n_sync - s0 < 2 * flen; k++) @(posedge clk);
    chk(32'(n_sync - s0 >= 2 * flen), 32'h1);
    wr(`PDTS_CTRL_OFS, 32'h0);
    wr(`PDTS_CTRL_OFS, 32'h1);
    s0 = n_sync;
    for (k = 0; k < 3000 && n_sync == s0; k++) @(posedge clk);
    wr(`PDTS_CTRL_OFS, 32'h0);
    rd(`PDTS_STATUS_OFS);
    chk(32'(d[2:0]), 32'(PDTS_IDLE));
    b0 = n_bv;
    wa0 = write_addr;
    repeat (20) @(posedge clk);
    chk(n_bv, b0);
    chk(32'(write_addr), 32'(wa0));
    report_and_stop;
  end
endmodule : testbench
